// [core/serial_ctrl.sv]
// Contract
// [RQ1] Slave: select is input; low activates, miso drives; high makes all pins inputs.
// [RQ2] Slave: select rising resets bit counter and drops the partial byte.
// [RQ3] Master with select as output: select pin is plain output, no effect.
// [RQ4] Master with select input low: clear master bit, become slave, release pins.
// [RQ5] Forced drop to slave sets done flag and may raise the interrupt.
// [RQ6] Software must set master bit again after forced drop; handlers check it.
// [RQ7] Redirect bit picks primary or alternate pins, inverted on 24-pin package.
// [RQ8] Interrupt only when done flag, enable bit 7 and global enable are set.
// [RQ9] Nothing operates unless the enable bit 6 is one.
// [RQ10] Bit order bit one shifts lsb first, zero msb first.
// [RQ11] Master bit one is master, zero slave; control resets to zero.
// [RQ12] Polarity bit sets serial clock idle level high or low.
// [RQ13] Phase zero samples leading edge; phase one samples trailing edge.
// [RQ14] Rate bits divide by 4, 16, 64, 128 in master; ignored in slave.
// [RQ15] Double speed halves divisors to 2, 8, 32, 64.
// [RQ16] Shortest master clock is two clocks; external clock at most a quarter.
// [RQ17] Done flag sets per byte; cleared by vector or status read then data access.
// [RQ18] Data write during transfer sets collision; status read then data access clears.
// [RQ19] Status bits 5 to 1 read zero.
// [RQ20] Data write starts transmission; read returns receive buffer.
// [RQ21] Each bit driven on one edge and captured on the opposite edge.
// [RQ22] Master write starts clock, shifts eight bits, stops, sets done flag.
// [RQ23] Single-buffered transmit, double-buffered receive; unread byte overwritten.
// [RQ24] Slave clock and select are synchronised before edge detection.
// [RQ25] Master clock idles at polarity level when no transfer runs.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module serial_ctrl #(
  parameter bit PKG_24_PIN = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_global_irq_en,
  input wire logic i_vector_ack,
  input wire logic i_sel_is_output,
  input wire logic i_miso_out_allowed,
  output logic o_irq,
  output logic o_use_alt_pins,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe_n,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe_n,
  input wire logic i_sel_n
);

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} phase_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic double_speed;
    logic pin_redirect_sel;
    logic done;
    logic write_collision_flag;
    logic armed;
    logic [7:0] shift;
    logic [7:0] rx_buf;
    logic [3:0] bitcnt;
    logic [6:0] divcnt;
    phase_t phase;
    logic in_bit;
    logic [1:0] sck_sync;
    logic [1:0] sel_sync;
    logic [1:0] miso_sync;
    logic [1:0] mosi_sync;
    logic sck_prev;
    logic sel_prev;
    logic [7:0] rdata;
    logic irq;
    logic use_alt;
    logic sck;
    logic sck_oe_n;
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic enabled;
  logic master;
  logic clock_idle_polarity;
  logic clock_sample_phase;
  logic lsb_first;
  logic out_bit;
  logic [6:0] half_period;
  logic sck_s;
  logic sel_s;
  logic slave_active;
  logic sck_rise;
  logic sck_fall;
  logic lead_edge;
  logic trail_edge;
  logic data_access;
  logic busy;

  // ==========================================================================
  // Decoded control and synchronised pin levels.
  // ==========================================================================
  // Only the second stage of each synchroniser is read. [RQ24]
  assign enabled = st_reg.ctl[serial_ctrl_pkg::CTL_IFACE_EN];
  assign master = st_reg.ctl[serial_ctrl_pkg::CTL_MASTER];
  assign clock_idle_polarity = st_reg.ctl[serial_ctrl_pkg::CTL_CLOCK_IDLE_POLARITY];
  assign clock_sample_phase = st_reg.ctl[serial_ctrl_pkg::CTL_CLOCK_SAMPLE_PHASE];
  assign lsb_first = st_reg.ctl[serial_ctrl_pkg::CTL_LSB_FIRST];
  assign sck_s = st_reg.sck_sync[1];
  assign sel_s = st_reg.sel_sync[1];
  assign sck_rise = sck_s & ~st_reg.sck_prev;
  assign sck_fall = ~sck_s & st_reg.sck_prev;
  // Leading edge is rising for idle-low polarity, falling otherwise. [RQ12]
  assign lead_edge = clock_idle_polarity ? sck_fall : sck_rise;
  assign trail_edge = clock_idle_polarity ? sck_rise : sck_fall;
  assign slave_active = enabled & ~master & ~sel_s; // [RQ1]
  assign out_bit = lsb_first ? st_reg.shift[0] : st_reg.shift[7]; // [RQ10]
  assign data_access = (i_wr | i_rd) && i_addr == serial_ctrl_pkg::ADDR_DATA;
  assign busy = master ? st_reg.phase != ST_IDLE : st_reg.bitcnt != 4'h0;

  // Half-period of the master clock from the rate and double-speed bits.
  // Each half period is counted in system clocks; the full serial clock
  // period is twice the value picked here.
  always_comb begin
    unique case ({st_reg.double_speed, st_reg.ctl[serial_ctrl_pkg::CTL_RATE_HI],
                  st_reg.ctl[serial_ctrl_pkg::CTL_RATE_LO]})
      3'h0: half_period = serial_ctrl_pkg::HALF_DIV_4; // [RQ14]
      3'h1: half_period = serial_ctrl_pkg::HALF_DIV_16;
      3'h2: half_period = serial_ctrl_pkg::HALF_DIV_64;
      3'h3: half_period = serial_ctrl_pkg::HALF_DIV_128;
      3'h4: half_period = serial_ctrl_pkg::HALF_DIV_2; // [RQ15] [RQ16]
      3'h5: half_period = serial_ctrl_pkg::HALF_DIV_8;
      3'h6: half_period = serial_ctrl_pkg::HALF_DIV_32;
      3'h7: half_period = serial_ctrl_pkg::HALF_DIV_64;
    endcase
  end

  // ==========================================================================
  // Next-state logic for registers, shifter and pins.
  // ==========================================================================
  // One process computes the whole next state so priorities stay in one place.
  always_comb begin
    logic shift_in;
    logic byte_done;
    logic [7:0] shifted;
    logic shift_bit;
    shift_in = 1'b0;
    shift_bit = 1'b0;
    byte_done = 1'b0;
    shifted = BYTE_ZERO_F();
    st_next = st_reg;
    st_next.sck_sync = {st_reg.sck_sync[0], i_sck};
    st_next.sel_sync = {st_reg.sel_sync[0], i_sel_n};
    st_next.miso_sync = {st_reg.miso_sync[0], i_miso};
    st_next.mosi_sync = {st_reg.mosi_sync[0], i_mosi};
    st_next.sck_prev = sck_s;
    st_next.sel_prev = sel_s;

    // The clear sequence is two steps: a status read that finds a flag set arms
    // the clear, and the next data read or write then drops both flags. A byte
    // that ends in that same cycle still sets the done flag, because the
    // completion is written after the clear in this process.
    // Status read with a flag set arms the clear; the next data access clears.
    if (data_access && st_reg.armed) begin
      st_next.done = 1'b0; // [RQ17]
      st_next.write_collision_flag = 1'b0; // [RQ18]
      st_next.armed = 1'b0;
    end
    if (i_vector_ack) begin
      st_next.done = 1'b0; // [RQ17]
    end
    if (i_rd && i_addr == serial_ctrl_pkg::ADDR_STATUS && (st_reg.done | st_reg.write_collision_flag)) begin
      st_next.armed = 1'b1;
    end

    // Register writes; control resets to zero and steers all operation.
    if (i_wr) begin
      unique case (i_addr)
        serial_ctrl_pkg::ADDR_CONTROL: st_next.ctl = i_wdata; // [RQ11]
        serial_ctrl_pkg::ADDR_STATUS: st_next.double_speed = i_wdata[serial_ctrl_pkg::STS_DOUBLE];
        serial_ctrl_pkg::ADDR_PIN_REDIRECT: st_next.pin_redirect_sel = i_wdata[serial_ctrl_pkg::PINSEL_BIT];
        default: begin
          if (busy) begin
            st_next.write_collision_flag = 1'b1; // [RQ18]
          end else begin
            st_next.shift = i_wdata; // [RQ20] [RQ23]
            if (enabled && master) begin
              st_next.phase = ST_LEAD; // [RQ22]
              st_next.divcnt = 7'h00;
              st_next.bitcnt = 4'h0;
              // Phase zero puts the first bit out before the leading edge. [RQ13]
            end
          end
        end
      endcase
    end

    // Master clock generator and shifter.
    if (enabled && master && st_reg.phase != ST_IDLE) begin
      if (st_reg.divcnt + 7'h01 >= half_period) begin
        st_next.divcnt = 7'h00;
        if (st_reg.phase == ST_LEAD) begin
          st_next.sck = ~clock_idle_polarity;
          st_next.phase = ST_TRAIL;
          if (!clock_sample_phase) begin
            st_next.in_bit = st_reg.miso_sync[1]; // [RQ13] [RQ21]
          end else begin
            st_next.mosi = out_bit;
          end
        end else begin
          st_next.sck = clock_idle_polarity;
          shift_in = 1'b1;
          if (st_reg.bitcnt == serial_ctrl_pkg::BITS_PER_BYTE - 4'h1) begin
            byte_done = 1'b1;
            st_next.phase = ST_IDLE; // [RQ22]
          end else begin
            st_next.phase = ST_LEAD;
          end
        end
      end else begin
        st_next.divcnt = st_reg.divcnt + 7'h01;
      end
    end
    if (!(enabled && master && st_reg.phase != ST_IDLE)) begin
      st_next.sck = clock_idle_polarity; // [RQ25]
    end
    if (enabled && master && st_reg.phase != ST_IDLE && !clock_sample_phase && st_reg.phase == ST_LEAD) begin
      st_next.mosi = out_bit;
    end

    // Slave shifter driven by synchronised clock edges.
    // Edges are seen two cycles after the pin moves, which is why the far
    // master must keep its clock at a quarter of the system clock or slower.
    if (slave_active) begin
      if (clock_sample_phase ? trail_edge : lead_edge) begin
        st_next.in_bit = st_reg.mosi_sync[1]; // [RQ13] [RQ21]
        shift_in = 1'b1;
        if (st_reg.bitcnt == serial_ctrl_pkg::BITS_PER_BYTE - 4'h1) begin
          byte_done = 1'b1;
        end
      end
      if (!clock_sample_phase || lead_edge) begin
        st_next.miso = out_bit;
      end
    end

    // Shift the sampled bit in at the master's trailing edge or at the slave's sampling edge.
    if (shift_in) begin
      // Pick the bit that this cell captured: the master reads the far side's
      // output line, the slave reads the far master's output line. In phase
      // zero the master caught its bit at the leading edge; otherwise the bit
      // is taken now, at the master's trailing edge or at the slave's sampling edge.
      if (master && !clock_sample_phase) begin
        shift_bit = st_reg.in_bit;
      end else if (master) begin
        shift_bit = st_reg.miso_sync[1]; // [RQ13]
      end else begin
        shift_bit = sample_now();
      end
      shifted = lsb_first ? {shift_bit, st_reg.shift[7:1]} : {st_reg.shift[6:0], shift_bit};
      st_next.shift = shifted;
      st_next.bitcnt = byte_done ? 4'h0 : st_reg.bitcnt + 4'h1;
      if (byte_done) begin
        st_next.rx_buf = shifted; // [RQ23]
        st_next.done = 1'b1; // [RQ17] [RQ22]
      end
    end

    // Select going high drops the partial byte and the bit count. [RQ2]
    if (enabled && !master && sel_s && !st_reg.sel_prev) begin
      st_next.bitcnt = 4'h0;
      st_next.shift = BYTE_ZERO_F();
    end

    // Select pulled low while master with select as input forces slave role.
    if (enabled && master && !i_sel_is_output && !sel_s) begin
      st_next.ctl[serial_ctrl_pkg::CTL_MASTER] = 1'b0; // [RQ4]
      st_next.done = 1'b1; // [RQ5] [RQ6]
      st_next.phase = ST_IDLE;
      st_next.bitcnt = 4'h0;
    end

    // Interface disabled: nothing runs. [RQ9]
    if (!enabled) begin
      st_next.phase = ST_IDLE;
      st_next.bitcnt = 4'h0;
    end

    // Registered pin directions and read data.
    // The master drives clock and data out only while enabled and in master
    // role; once the role drops, both lines are released on the next edge so
    // that two masters never fight over them.
    // Select as output in master role is left to port logic. [RQ3]
    st_next.sck_oe_n = ~(enabled && master); // [RQ1]
    st_next.mosi_oe_n = ~(enabled && master);
    st_next.miso_oe_n = ~(slave_active && i_miso_out_allowed); // [RQ1]
    st_next.irq = st_next.done && st_next.ctl[serial_ctrl_pkg::CTL_IRQ_EN] && i_global_irq_en; // [RQ8] [RQ5]
    st_next.use_alt = st_reg.pin_redirect_sel ^ PKG_24_PIN; // [RQ7]
    st_next.rdata = serial_ctrl_pkg::BYTE_ZERO;
    if (i_rd) begin
      unique case (i_addr)
        serial_ctrl_pkg::ADDR_CONTROL: st_next.rdata = st_reg.ctl;
        serial_ctrl_pkg::ADDR_STATUS: st_next.rdata = {st_reg.done, st_reg.write_collision_flag, 5'h00, st_reg.double_speed}; // [RQ19]
        serial_ctrl_pkg::ADDR_DATA: st_next.rdata = st_reg.rx_buf; // [RQ20]
        default: st_next.rdata = {st_reg.pin_redirect_sel, 7'h00};
      endcase
    end
  end

  // Bit caught for the current slave sample.
  function automatic logic sample_now();
    sample_now = st_reg.mosi_sync[1];
  endfunction

  function automatic logic [7:0] BYTE_ZERO_F();
    BYTE_ZERO_F = serial_ctrl_pkg::BYTE_ZERO;
  endfunction

  // ==========================================================================
  // Limitations.
  // ==========================================================================
  // The master sees its input line through the two-stage synchroniser, so a
  // bit placed on the line by the far side reaches the sampling point two
  // cycles late. At the two fastest rates the sample can therefore miss the
  // bit that was just set up; a rate of sixteen or slower leaves ample margin.
  // The redirect output only tells the port logic which pin set to use; the
  // programming port sits on the alternate set whatever this bit says.

  // ==========================================================================
  // State register.
  // ==========================================================================
  // Every flop resets to a constant; idle pins released.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
      st_reg.ctl <= serial_ctrl_pkg::CONTROL_RESET; // [RQ11]
      st_reg.phase <= ST_IDLE;
      st_reg.sck_oe_n <= 1'b1;
      st_reg.mosi_oe_n <= 1'b1;
      st_reg.miso_oe_n <= 1'b1;
      st_reg.sel_sync <= 2'h3;
      st_reg.sel_prev <= 1'b1;
      st_reg.use_alt <= PKG_24_PIN;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flops.
  assign o_rdata = st_reg.rdata;
  assign o_irq = st_reg.irq;
  assign o_use_alt_pins = st_reg.use_alt;
  assign o_sck = st_reg.sck;
  assign o_sck_oe_n = st_reg.sck_oe_n;
  assign o_mosi = st_reg.mosi;
  assign o_mosi_oe_n = st_reg.mosi_oe_n;
  assign o_miso = st_reg.miso;
  assign o_miso_oe_n = st_reg.miso_oe_n;

endmodule

`default_nettype wire

// [core/serial_ctrl_pkg.sv]
package serial_ctrl_pkg;

  // ==========================================================================
  // Register addresses on the plain register port.
  // ==========================================================================
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;
  localparam logic [1:0] ADDR_PIN_REDIRECT = 2'h3;

  // ==========================================================================
  // Control register field positions.
  // ==========================================================================
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_IFACE_EN = 6;
  localparam int CTL_LSB_FIRST = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CLOCK_IDLE_POLARITY = 3;
  localparam int CTL_CLOCK_SAMPLE_PHASE = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;

  // ==========================================================================
  // Status register and pin redirect field positions.
  // ==========================================================================
  localparam int STS_DONE = 7;
  localparam int STS_WRITE_COLLISION_FLAG = 6;
  localparam int STS_DOUBLE = 0;
  localparam int PINSEL_BIT = 7;

  // ==========================================================================
  // Reset values and counts.
  // ==========================================================================
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] HALF_DIV_4 = 7'h02;
  localparam logic [6:0] HALF_DIV_16 = 7'h08;
  localparam logic [6:0] HALF_DIV_64 = 7'h20;
  localparam logic [6:0] HALF_DIV_128 = 7'h40;
  localparam logic [6:0] HALF_DIV_2 = 7'h01;
  localparam logic [6:0] HALF_DIV_8 = 7'h04;
  localparam logic [6:0] HALF_DIV_32 = 7'h10;

endpackage

// [tb/serial_ctrl_assertions.sv]
`timescale 1ns/10ps
`default_nettype none

module serial_ctrl_assertions (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_global_irq_en,
  input wire logic i_miso_out_allowed,
  input wire logic o_irq,
  input wire logic o_sck,
  input wire logic o_sck_oe_n,
  input wire logic o_mosi_oe_n,
  input wire logic o_miso_oe_n,
  input wire logic i_sel_n
);
  logic [7:0] ctl_q;
  logic dbl_q;

  // ==========================================================================
  // Shadow of what software last wrote to control and double speed.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_q <= 8'h00;
      dbl_q <= 1'b0;
    end else if (i_wr && i_addr == serial_ctrl_pkg::ADDR_CONTROL) begin
      ctl_q <= i_wdata;
    end else if (i_wr && i_addr == serial_ctrl_pkg::ADDR_STATUS) begin
      dbl_q <= i_wdata[serial_ctrl_pkg::STS_DOUBLE];
    end
  end

  // ==========================================================================
  // Port relations.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_sel_high;
    i_sel_n [*6];
  endsequence

  chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_status_resv: assert property ($past(i_rd) && $past(i_addr) == serial_ctrl_pkg::ADDR_STATUS |-> o_rdata[5:1] == 5'h00)
    else $error("reserved status bits not zero");
  chk_ctl_readback: assert property ($past(i_rd) && $past(i_addr) == serial_ctrl_pkg::ADDR_CONTROL
    |-> {o_rdata[7:5], o_rdata[3:0]} == {$past(ctl_q[7:5]), $past(ctl_q[3:0])})
    else $error("control readback differs from written value");
  chk_irq_gate: assert property (o_irq |-> ctl_q[7] && $past(i_global_irq_en))
    else $error("interrupt without both enables");
  chk_off_quiet: assert property ((!ctl_q[6]) [*2] |-> o_sck_oe_n && o_mosi_oe_n && o_miso_oe_n)
    else $error("pin driven while interface disabled");
  chk_slave_pins: assert property ((!ctl_q[4]) [*2] |-> o_sck_oe_n && o_mosi_oe_n)
    else $error("clock or mosi driven in slave role");
  chk_miso_release: assert property (s_sel_high |-> o_miso_oe_n)
    else $error("miso driven while select high");
  chk_miso_gate: assert property (!o_miso_oe_n |-> $past(i_miso_out_allowed))
    else $error("miso driven without user permission");
  chk_sck_min_half: assert property (!dbl_q && !o_sck_oe_n && $changed(o_sck) |=> $stable(o_sck))
    else $error("serial clock half period below two cycles");
endmodule

`default_nettype wire

// [tb/spi_far_slave.sv]
`timescale 1ns/10ps
`default_nettype none

module spi_far_slave (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  input wire logic i_clock_idle_polarity,
  input wire logic i_clock_sample_phase,
  input wire logic i_lsb,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  int n;

  // Next outgoing bit; past the byte the line shows the inverse of the last bit.
  function automatic logic bit_at(input int k);
    if (k > 7) return ~o_miso;
    return i_tx[i_lsb ? k : 7 - k];
  endfunction

  // Start from a known state.
  initial begin
    o_miso = 1'b0;
    o_rx = 8'h00;
    n = 0;
  end

  // Selection restarts the count and presents the first bit.
  always @(negedge i_sel_n) begin
    n = 0;
    o_miso = bit_at(0);
  end

  // Deselection leaves no stale data bit on the line.
  always @(posedge i_sel_n) o_miso = ~o_miso;

  // Capture on the sampling edge, present the next bit on the other.
  always @(i_sck) begin
    if (!i_sel_n) begin
      if ((i_sck != i_clock_idle_polarity) ^ i_clock_sample_phase) begin
        o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
        n = n + 1;
      end else begin
        o_miso = bit_at(n);
      end
    end
  end
endmodule

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic i_sys_clk, i_nrst, i_wr, i_rd, gie, ack, sel_out, sel_n, miso, alt, mo;
  logic [1:0] i_addr;
  logic [7:0] i_wdata, d, ctl, far_tx, far_rx, o_rdata;
  logic o_irq, o_sck, o_sck_oe_n, o_mosi, o_mosi_oe_n, o_miso_oe_n;
  int bad_count, compares, n;

  serial_ctrl uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_en(gie), .i_vector_ack(ack), .i_sel_is_output(sel_out),
    .i_miso_out_allowed(mo), .o_irq(o_irq), .o_use_alt_pins(alt), .i_sck(1'b0), .o_sck(o_sck),
    .o_sck_oe_n(o_sck_oe_n), .i_mosi(1'b0), .o_mosi(o_mosi), .o_mosi_oe_n(o_mosi_oe_n), .i_miso(miso),
    .o_miso(), .o_miso_oe_n(o_miso_oe_n), .i_sel_n(sel_n));

  spi_far_slave far (.i_sck(o_sck), .i_mosi(o_mosi), .i_sel_n(sel_n), .i_clock_idle_polarity(ctl[3]), .i_clock_sample_phase(ctl[2]),
    .i_lsb(ctl[5]), .i_tx(far_tx), .o_miso(miso), .o_rx(far_rx));

  // Free-running system clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic poll;
    for (int k = 0; k < 1500; k++) begin
      rd(serial_ctrl_pkg::ADDR_STATUS);
      if (d[7] === 1'b1) break;
    end
  endtask

  // Counts cycles between two serial clock changes.
  task automatic gap;
    logic s;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      s = o_sck;
      while (o_sck === s && n < 300) begin
        @(posedge i_sys_clk);
        n++;
      end
    end
  endtask

  task automatic t_reset;
    rd(serial_ctrl_pkg::ADDR_CONTROL);
    chk(d, 8'h00);
    rd(serial_ctrl_pkg::ADDR_STATUS);
    chk(d & 8'h3E, 8'h00);
    chk({7'h0, alt}, 8'h00);
    wr(serial_ctrl_pkg::ADDR_PIN_REDIRECT, 8'h80);
    repeat (2) @(posedge i_sys_clk);
    chk({7'h0, alt}, 8'h01);
  endtask

  task automatic t_disabled;
    wr(serial_ctrl_pkg::ADDR_CONTROL, 8'h10);
    wr(serial_ctrl_pkg::ADDR_DATA, 8'hA5);
    repeat (200) @(posedge i_sys_clk);
    rd(serial_ctrl_pkg::ADDR_STATUS);
    chk(d & 8'h80, 8'h00);
  endtask

  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      ctl = 8'hD1 | 8'(i << 2) | (i[0] ? 8'h20 : 8'h00);
      far_tx = 8'hC4 - 8'(i);
      wr(serial_ctrl_pkg::ADDR_CONTROL, ctl);
      sel_n <= 1'b0;
      wr(serial_ctrl_pkg::ADDR_DATA, 8'h1D + 8'(i));
      n = 0;
      while (o_irq !== 1'b1 && n < 400) begin
        @(posedge i_sys_clk);
        n++;
      end
      chk({7'h0, o_irq}, 8'h01);
      chk({7'h0, o_sck}, {7'h0, ctl[3]});
      rd(serial_ctrl_pkg::ADDR_STATUS);
      chk(d & 8'h80, 8'h80);
      rd(serial_ctrl_pkg::ADDR_DATA);
      chk(d, far_tx);
      chk(far_rx, 8'h1D + 8'(i));
      rd(serial_ctrl_pkg::ADDR_STATUS);
      chk(d & 8'h80, 8'h00);
      sel_n <= 1'b1;
    end
  endtask

  task automatic t_rates;
    sel_n <= 1'b0;
    for (int j = 0; j < 8; j++) begin
      ctl = 8'h50 | 8'(j & 3);
      wr(serial_ctrl_pkg::ADDR_STATUS, 8'(j >> 2));
      wr(serial_ctrl_pkg::ADDR_CONTROL, ctl);
      wr(serial_ctrl_pkg::ADDR_DATA, 8'h5A);
      gap();
      chk(8'(n), (((j & 3) == 3) ? 8'h40 : (8'h02 << (2 * (j & 3)))) >> (j >> 2));
      poll();
      rd(serial_ctrl_pkg::ADDR_DATA);
    end
  endtask

  task automatic t_collision;
    ctl = 8'h51;
    wr(serial_ctrl_pkg::ADDR_CONTROL, ctl);
    wr(serial_ctrl_pkg::ADDR_DATA, 8'h11);
    wr(serial_ctrl_pkg::ADDR_DATA, 8'h22);
    poll();
    chk(d & 8'hC0, 8'hC0);
    rd(serial_ctrl_pkg::ADDR_DATA);
    chk(far_rx, 8'h11);
    rd(serial_ctrl_pkg::ADDR_STATUS);
    chk(d & 8'hC0, 8'h00);
    sel_n <= 1'b1;
  endtask

  task automatic t_drop;
    ctl = 8'hD1;
    wr(serial_ctrl_pkg::ADDR_CONTROL, ctl);
    sel_n <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    rd(serial_ctrl_pkg::ADDR_CONTROL);
    chk(d, 8'hD1);
    sel_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    sel_out <= 1'b0;
    sel_n <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    rd(serial_ctrl_pkg::ADDR_CONTROL);
    chk(d, 8'hC1);
    chk({6'h0, o_sck_oe_n, o_mosi_oe_n}, 8'h03);
    chk({7'h0, o_irq}, 8'h01);
    chk({7'h0, o_miso_oe_n}, 8'h00);
    mo <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    chk({7'h0, o_miso_oe_n}, 8'h01);
    mo <= 1'b1;
    @(posedge i_sys_clk);
    ack <= 1'b1;
    @(posedge i_sys_clk);
    ack <= 1'b0;
    rd(serial_ctrl_pkg::ADDR_STATUS);
    chk(d & 8'h80, 8'h00);
    sel_n <= 1'b1;
    sel_out <= 1'b1;
    wr(serial_ctrl_pkg::ADDR_CONTROL, ctl);
    rd(serial_ctrl_pkg::ADDR_CONTROL);
    chk(d, 8'hD1);
  endtask

  task automatic close_out;
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    bad_count++;
    close_out();
  end

  // Main sequence.
  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 2'h0;
    i_wdata = 8'h00;
    gie = 1'b1;
    ack = 1'b0;
    sel_out = 1'b1;
    mo = 1'b1;
    sel_n = 1'b1;
    ctl = 8'h00;
    far_tx = 8'h00;
    repeat (12) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_disabled();
    t_modes();
    t_rates();
    t_collision();
    t_drop();
    close_out();
  end
endmodule

bind serial_ctrl serial_ctrl_assertions chk_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_en(i_global_irq_en),
  .i_miso_out_allowed(i_miso_out_allowed), .o_irq(o_irq), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n),
  .o_mosi_oe_n(o_mosi_oe_n), .o_miso_oe_n(o_miso_oe_n), .i_sel_n(i_sel_n));

`default_nettype wire
